// >>> include/odp_pkg.sv
// Shared constants and encodings for the operand data path
package odp_pkg;

  localparam int unsigned ODP_WIDTH = 16;
  localparam int unsigned ODP_REGS  = 16;
  localparam int unsigned ODP_AW    = 4;
  localparam int unsigned ODP_BYTE  = 8;
  localparam int unsigned ODP_MSB   = 15;
  localparam int unsigned ODP_LSB_SIGN = 7;

  // Data multiplexer source select
  typedef enum logic [1:0] {
    ODP_DSEL_READ  = 2'b00,
    ODP_DSEL_BUS   = 2'b01,
    ODP_DSEL_DREG  = 2'b10,
    ODP_DSEL_SHIFT = 2'b11
  } odp_dsel_t;

  // Operand multiplexer mode select
  typedef enum logic [2:0] {
    ODP_BMODE_DIRECT = 3'b000,
    ODP_BMODE_SIGNX  = 3'b001,
    ODP_BMODE_DUPHI  = 3'b010,
    ODP_BMODE_DUPLO  = 3'b011,
    ODP_BMODE_SWAP   = 3'b100,
    ODP_BMODE_CONST  = 3'b101
  } odp_bmode_t;

  // Carry extension source select
  typedef enum logic [1:0] {
    ODP_CSEL_WORD   = 2'b00,
    ODP_CSEL_BYTE   = 2'b01,
    ODP_CSEL_ALU15  = 2'b10,
    ODP_CSEL_STATUS = 2'b11
  } odp_csel_t;

  // Read bus source select
  typedef enum logic [1:0] {
    ODP_RSEL_NONE   = 2'b00,
    ODP_RSEL_GREG   = 2'b01,
    ODP_RSEL_STATUS = 2'b10
  } odp_rsel_t;

  localparam int unsigned ODP_CSEL_W = 4;
  localparam logic [15:0] ODP_K_ONE     = 16'h0001;
  localparam logic [15:0] ODP_K_TWO     = 16'h0002;
  localparam logic [15:0] ODP_K_MINUS1  = 16'hffff;
  localparam logic [15:0] ODP_K_MINUS2  = 16'hfffe;
  localparam logic [15:0] ODP_K_OFFMASK = 16'h00ff;
  localparam logic [15:0] ODP_K_HIMASK  = 16'hff00;
  localparam logic [15:0] ODP_K_ZERO    = 16'h0000;
  localparam logic [15:0] ODP_RST_WORD  = 16'h0000;

endpackage

// >>> rtl/odp_regfile.sv
// Sixteen-word scratch-pad register file, single port
`timescale 1ns/1ps
module odp_regfile
  import odp_pkg::*;
#(
  parameter int unsigned WIDTH = ODP_WIDTH,
  parameter int unsigned DEPTH = ODP_REGS,
  parameter int unsigned AW    = ODP_AW
) (
  input  wire logic             clk_in,
  input  wire logic [AW-1:0]    addr_in,
  input  wire logic             wr_en_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic      [WIDTH-1:0] rd_data_out
);

  initial begin
    if (DEPTH != (1 << AW)) begin
      $error("odp_regfile: DEPTH must equal 2**AW");
    end
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];

  // One address per cycle; a write cycle presents no read data
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_reg[addr_in] <= wr_data_in;
    end
  end

  assign rd_data_out = wr_en_in ? '0 : mem_reg[addr_in];

endmodule

// >>> rtl/odp_bmux.sv
// Operand multiplexer: constant or transformed holding register onto B
`timescale 1ns/1ps
module odp_bmux
  import odp_pkg::*;
(
  input  wire logic [15:0]  hold_in,
  input  wire odp_bmode_t   mode_in,
  input  wire logic [ODP_CSEL_W-1:0] const_sel_in,
  input  wire logic [15:0]  jumper_const_in,
  input  wire logic [15:0]  status_const_in,
  input  wire logic [15:0]  switch_addr_in,
  input  wire logic [15:0]  trap_vector_in,
  output logic      [15:0]  alu_b_operand_out
);

  logic [7:0]  hi_byte;
  logic [7:0]  lo_byte;
  logic [15:0] const_word;

  assign hi_byte = hold_in[ODP_MSB:ODP_BYTE];
  assign lo_byte = hold_in[ODP_BYTE-1:0];

  function automatic logic [15:0] pick_const(input logic [ODP_CSEL_W-1:0] sel,
                                              input logic [15:0] jmp,
                                              input logic [15:0] sts,
                                              input logic [15:0] swa,
                                              input logic [15:0] trp);
    case (sel)
      4'h0:    pick_const = ODP_K_ONE;
      4'h1:    pick_const = ODP_K_TWO;
      4'h2:    pick_const = ODP_K_MINUS1;
      4'h3:    pick_const = ODP_K_MINUS2;
      4'h4:    pick_const = swa;
      4'h5:    pick_const = trp;
      4'h6:    pick_const = ODP_K_OFFMASK;
      4'h7:    pick_const = ODP_K_HIMASK;
      4'h8:    pick_const = sts;
      4'h9:    pick_const = jmp;
      default: pick_const = ODP_K_ZERO;
    endcase
  endfunction

  assign const_word = pick_const(const_sel_in, jumper_const_in, status_const_in,
                                 switch_addr_in, trap_vector_in);

  always_comb begin
    case (mode_in)
      ODP_BMODE_DIRECT: alu_b_operand_out = hold_in;
      ODP_BMODE_SIGNX:  alu_b_operand_out = {{8{hold_in[ODP_LSB_SIGN]}}, lo_byte};
      ODP_BMODE_DUPHI:  alu_b_operand_out = {hi_byte, hi_byte};
      ODP_BMODE_DUPLO:  alu_b_operand_out = {lo_byte, lo_byte};
      ODP_BMODE_SWAP:   alu_b_operand_out = {lo_byte, hi_byte};
      ODP_BMODE_CONST:  alu_b_operand_out = const_word;
      default:          alu_b_operand_out = hold_in;
    endcase
  end

endmodule

// >>> rtl/odp_datapath.sv
// Operand data path around the ALU: register file, muxes, result registers
`timescale 1ns/1ps
module odp_datapath
  import odp_pkg::*;
#(
  parameter int unsigned WIDTH = ODP_WIDTH,
  parameter int unsigned NREGS = ODP_REGS,
  parameter int unsigned AW    = ODP_AW
) (
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  // Register file control
  input  wire logic [AW-1:0]         reg_addr_in,
  input  wire logic                  reg_wr_in,
  input  wire odp_rsel_t             read_sel_in,
  input  wire logic                  status_wr_in,
  // Multiplexer selects from the microword
  input  wire odp_dsel_t             dmux_sel_in,
  input  wire odp_bmode_t            bmode_in,
  input  wire logic [ODP_CSEL_W-1:0] const_sel_in,
  input  wire odp_csel_t             carry_out_select_in,
  // Load enables and the address mux select
  input  wire logic                  hold_ld_in,
  input  wire logic                  dreg_ld_in,
  input  wire logic                  addr_ld_in,
  input  wire logic                  bam_alu_in,
  // ALU side
  input  wire logic [WIDTH-1:0]      alu_result_in,
  input  wire logic                  alu_cout15_in,
  input  wire logic                  alu_cout7_in,
  // Machine dependent constants
  input  wire logic [WIDTH-1:0]      jumper_const_in,
  input  wire logic [WIDTH-1:0]      switch_addr_in,
  input  wire logic [WIDTH-1:0]      trap_vector_in,
  // System bus data receivers
  input  wire logic [WIDTH-1:0]      bus_data_in,
  // Outputs
  output logic      [WIDTH-1:0]      alu_a_operand_out,
  output logic      [WIDTH-1:0]      alu_b_operand_out,
  output logic      [WIDTH-1:0]      dreg_out,
  output logic      [WIDTH-1:0]      bus_addr_out,
  output logic      [WIDTH-1:0]      dmux_out,
  output logic                       carry_ext_out,
  output logic      [WIDTH-1:0]      processor_status_out
);

  initial begin
    if (WIDTH != ODP_WIDTH) begin
      $error("odp_datapath: byte views require a 16-bit word");
    end
    if (NREGS != (1 << AW)) begin
      $error("odp_datapath: NREGS must equal 2**AW");
    end
    if (ODP_MSB != WIDTH - 1) begin
      $error("odp_datapath: shift source assumes the top bit is WIDTH-1");
    end
    if (AW == 0) begin
      $error("odp_datapath: register file needs at least one address bit");
    end
  end

  // Bus data arrives from another clock domain; two stages before use
  logic [WIDTH-1:0] bus_sync1_reg;
  logic [WIDTH-1:0] bus_sync2_reg;

  logic [WIDTH-1:0] hold_reg;
  logic [WIDTH-1:0] hold_next;
  logic [WIDTH-1:0] dreg_reg;
  logic [WIDTH-1:0] dreg_next;
  logic             carry_reg;
  logic             carry_next;
  logic [WIDTH-1:0] addr_reg;
  logic [WIDTH-1:0] addr_next;
  logic [WIDTH-1:0] status_reg;
  logic [WIDTH-1:0] status_next;
  logic [WIDTH-1:0] a_reg;
  logic [WIDTH-1:0] b_reg;
  logic [WIDTH-1:0] dmux_reg;

  logic [WIDTH-1:0] gr_rd_data;
  logic [WIDTH-1:0] read_bus;
  logic [WIDTH-1:0] read_buf;
  logic [WIDTH-1:0] dreg_shifted;
  logic [WIDTH-1:0] dmux_word;
  logic [WIDTH-1:0] bmux_word;
  logic [WIDTH-1:0] status_const;
  logic             carry_pick;
  logic             gr_write;
  logic [WIDTH-1:0] addr_src;

  // Writing the file suppresses the read so a cycle is one or the other
  assign gr_write = reg_wr_in;

  odp_regfile #(
    .WIDTH (WIDTH),
    .DEPTH (NREGS),
    .AW    (AW)
  ) u_regfile (
    .clk_in      (clk_in),
    .addr_in     (reg_addr_in),
    .wr_en_in    (gr_write),
    .wr_data_in  (alu_result_in),
    .rd_data_out (gr_rd_data)
  );

  // Read bus: selects the register file or the status word, zero when neither is selected
  function automatic logic [15:0] read_select(input odp_rsel_t sel,
                                               input logic [15:0] gr,
                                               input logic [15:0] ps);
    case (sel)
      ODP_RSEL_GREG:   read_select = gr;
      ODP_RSEL_STATUS: read_select = ps;
      default:         read_select = ODP_K_ZERO;
    endcase
  endfunction

  assign read_bus = read_select(read_sel_in, gr_rd_data, status_reg);
  assign read_buf = read_bus;

  assign dreg_shifted = {carry_reg, dreg_reg[ODP_MSB:1]};

  // Data multiplexer is the only entry for bus receiver data
  function automatic logic [15:0] data_select(input odp_dsel_t   sel,
                                               input logic [15:0] rd,
                                               input logic [15:0] bus,
                                               input logic [15:0] dr,
                                               input logic [15:0] sh);
    case (sel)
      ODP_DSEL_READ:  data_select = rd;
      ODP_DSEL_BUS:   data_select = bus;
      ODP_DSEL_DREG:  data_select = dr;
      ODP_DSEL_SHIFT: data_select = sh;
      default:        data_select = rd;
    endcase
  endfunction

  assign dmux_word = data_select(dmux_sel_in, read_buf, bus_sync2_reg, dreg_reg,
                                 dreg_shifted);

  // Status carry lives in bit 0 of the status word
  function automatic logic carry_select(input odp_csel_t sel,
                                        input logic      c15,
                                        input logic      c7,
                                        input logic      msb,
                                        input logic      ps_c);
    case (sel)
      ODP_CSEL_WORD:   carry_select = c15;
      ODP_CSEL_BYTE:   carry_select = c7;
      ODP_CSEL_ALU15:  carry_select = msb;
      ODP_CSEL_STATUS: carry_select = ps_c;
      default:         carry_select = c15;
    endcase
  endfunction

  assign carry_pick = carry_select(carry_out_select_in, alu_cout15_in, alu_cout7_in,
                                   alu_result_in[ODP_MSB], status_reg[0]);

  // Status-dependent constant offers the live status word
  assign status_const = status_reg;

  odp_bmux u_bmux (
    .hold_in           (hold_reg),
    .mode_in           (bmode_in),
    .const_sel_in      (const_sel_in),
    .jumper_const_in   (jumper_const_in),
    .status_const_in   (status_const),
    .switch_addr_in    (switch_addr_in),
    .trap_vector_in    (trap_vector_in),
    .alu_b_operand_out (bmux_word)
  );

  // Load-enable gating shared by the hold, data, address and status words
  function automatic logic [15:0] load_pick(input logic        en,
                                            input logic [15:0] nw,
                                            input logic [15:0] old);
    load_pick = en ? nw : old;
  endfunction

  // Address register takes the ALU or the read bus, as the address mux chooses
  assign addr_src    = bam_alu_in ? alu_result_in : read_bus;
  assign hold_next   = load_pick(hold_ld_in, dmux_word, hold_reg);
  assign dreg_next   = load_pick(dreg_ld_in, alu_result_in, dreg_reg);
  assign carry_next  = dreg_ld_in ? carry_pick : carry_reg;
  assign addr_next   = load_pick(addr_ld_in, addr_src, addr_reg);
  assign status_next = load_pick(status_wr_in, alu_result_in, status_reg);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_sync1_reg <= ODP_RST_WORD;
    end else begin
      bus_sync1_reg <= bus_data_in;
    end
  end

  // Only the second stage is read by the data path
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_sync2_reg <= ODP_RST_WORD;
    end else begin
      bus_sync2_reg <= bus_sync1_reg;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold_reg <= ODP_RST_WORD;
    end else begin
      hold_reg <= hold_next;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dreg_reg <= ODP_RST_WORD;
    end else begin
      dreg_reg <= dreg_next;
    end
  end

  // Carry extension travels with the data register load
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      carry_reg <= 1'b0;
    end else begin
      carry_reg <= carry_next;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_reg <= ODP_RST_WORD;
    end else begin
      addr_reg <= addr_next;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_reg <= ODP_RST_WORD;
    end else begin
      status_reg <= status_next;
    end
  end

  // Operand outputs are registered copies; ALU sees them one cycle later.
  // This trades a cycle of latency for registered top-level outputs.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      a_reg <= ODP_RST_WORD;
    end else begin
      a_reg <= read_bus;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      b_reg <= ODP_RST_WORD;
    end else begin
      b_reg <= bmux_word;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dmux_reg <= ODP_RST_WORD;
    end else begin
      dmux_reg <= dmux_word;
    end
  end

  assign alu_a_operand_out    = a_reg;
  assign alu_b_operand_out    = b_reg;
  assign dmux_out             = dmux_reg;
  assign dreg_out             = dreg_reg;
  assign bus_addr_out         = addr_reg;
  assign carry_ext_out        = carry_reg;
  assign processor_status_out = status_reg;

endmodule

// >>> dv/odp_bus_model.sv
// Behavioural bus data source facing the receivers
`timescale 1ns/1ps
module odp_bus_model (
  input  wire logic        clk_in,
  input  wire logic        drive_in,
  input  wire logic [15:0] word_in,
  output logic      [15:0] bus_data_out
);
  logic [15:0] last_reg = 16'h0000;
  // Released lines toggle each cycle, starting from the last driven word, so it reappears every other cycle
  always @(posedge clk_in) begin
    last_reg <= drive_in ? word_in : ~last_reg;
  end
  assign bus_data_out = drive_in ? word_in : last_reg;
endmodule

// >>> dv/odp_datapath_properties.sv
// Port-level checks for the operand data path
`timescale 1ns/1ps
module odp_datapath_chk
  import odp_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        reg_wr_in,
  input wire odp_rsel_t   read_sel_in,
  input wire logic        status_wr_in,
  input wire odp_dsel_t   dmux_sel_in,
  input wire odp_bmode_t  bmode_in,
  input wire logic [3:0]  const_sel_in,
  input wire odp_csel_t   carry_out_select_in,
  input wire logic        dreg_ld_in,
  input wire logic [15:0] alu_result_in,
  input wire logic        alu_cout15_in,
  input wire logic [15:0] alu_a_operand_out,
  input wire logic [15:0] alu_b_operand_out,
  input wire logic [15:0] dreg_out,
  input wire logic [15:0] dmux_out,
  input wire logic        carry_ext_out,
  input wire logic [15:0] processor_status_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_dload;
    dreg_ld_in;
  endsequence
  sequence s_word_carry;
    s_dload ##0 carry_out_select_in == ODP_CSEL_WORD;
  endsequence
  chk_dreg_capture:
    assert property (s_dload |=> dreg_out == $past(alu_result_in))
    else $error("data register missed the result");
  chk_dreg_hold:
    assert property (!dreg_ld_in |=> $stable(dreg_out))
    else $error("data register changed without load");
  chk_status_write:
    assert property (status_wr_in |=> processor_status_out == $past(alu_result_in))
    else $error("status register missed the result");
  chk_status_read:
    assert property (read_sel_in == ODP_RSEL_STATUS |=>
    alu_a_operand_out == $past(processor_status_out))
    else $error("status word not on A operand");
  chk_no_rw:
    assert property (reg_wr_in && read_sel_in == ODP_RSEL_GREG |=>
    alu_a_operand_out == 16'h0000)
    else $error("read during write cycle");
  chk_shift_view:
    assert property (dmux_sel_in == ODP_DSEL_SHIFT |=>
    dmux_out == ({$past(carry_ext_out), 15'h0000} | ($past(dreg_out) >> 1)))
    else $error("shifted source wrong");
  chk_dreg_view:
    assert property (dmux_sel_in == ODP_DSEL_DREG |=> dmux_out == $past(dreg_out))
    else $error("data register source wrong");
  chk_word_carry:
    assert property (s_word_carry |=> carry_ext_out == $past(alu_cout15_in))
    else $error("word carry not captured");
  chk_const_two:
    assert property (bmode_in == ODP_BMODE_CONST && const_sel_in == 4'h1 |=>
    alu_b_operand_out == ODP_K_TWO)
    else $error("constant two wrong");
endmodule
bind odp_datapath odp_datapath_chk u_odp_datapath_chk (.*);

// >>> dv/odp_datapath_tb_top.sv
// Self-checking bench for the operand data path
`timescale 1ns/1ps
module odp_datapath_tb_top
  import odp_pkg::*;
;
  logic        clk_in = 1'b0;
  logic        rst_n_in, reg_wr_in, status_wr_in, hold_ld_in, dreg_ld_in, addr_ld_in;
  logic        bam_alu_in, alu_cout15_in, alu_cout7_in, carry_ext_out, bus_drv;
  logic [3:0]  reg_addr_in, const_sel_in;
  odp_rsel_t   read_sel_in;
  odp_dsel_t   dmux_sel_in;
  odp_bmode_t  bmode_in;
  odp_csel_t   carry_out_select_in;
  logic [15:0] alu_result_in, jumper_const_in, switch_addr_in, trap_vector_in, bus_word;
  logic [15:0] bus_data_in, alu_a_operand_out, alu_b_operand_out, dreg_out, bus_addr_out;
  logic [15:0] dmux_out, processor_status_out;
  logic [15:0] mem [16];
  int          n_fail = 0;
  int          cmp_count = 0;

  always #2 clk_in = ~clk_in;

  odp_datapath u_odp_datapath (.*);
  odp_bus_model u_odp_bus_model (.clk_in(clk_in), .drive_in(bus_drv), .word_in(bus_word),
    .bus_data_out(bus_data_in));

  task automatic cyc();
    @(negedge clk_in);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  function automatic logic [15:0] exp_b(input odp_bmode_t m, input logic [15:0] h);
    case (m)
      ODP_BMODE_SIGNX: return {{8{h[7]}}, h[7:0]};
      ODP_BMODE_DUPHI: return {h[15:8], h[15:8]};
      ODP_BMODE_DUPLO: return {h[7:0], h[7:0]};
      ODP_BMODE_SWAP:  return {h[7:0], h[15:8]};
      default:         return h;
    endcase
  endfunction

  task automatic t_regfile();
    reg_wr_in = 1'b1;
    for (int i = 0; i < 16; i++) begin
      mem[i] = 16'h0f0f ^ (16'(i) * 16'h1357);
      reg_addr_in = 4'(i);
      alu_result_in = mem[i];
      cyc();
    end
    reg_wr_in = 1'b0;
    read_sel_in = ODP_RSEL_GREG;
    for (int i = 0; i < 16; i++) begin
      reg_addr_in = 4'(i);
      cyc();
      chk(alu_a_operand_out, mem[i]);
    end
    reg_addr_in = 4'h3;
    alu_result_in = 16'h6b1d;
    reg_wr_in = 1'b1;
    cyc();
    reg_wr_in = 1'b0;
    mem[3] = 16'h6b1d;
    chk(alu_a_operand_out, 16'h0000);
    cyc();
    chk(alu_a_operand_out, mem[3]);
  endtask

  task automatic t_reg2reg();
    reg_addr_in = 4'h1;
    hold_ld_in = 1'b1;
    cyc();
    hold_ld_in = 1'b0;
    reg_addr_in = 4'h2;
    chk(dmux_out, mem[1]);
    cyc();
    chk(alu_b_operand_out, mem[1]);
    chk(alu_a_operand_out, mem[2]);
    alu_result_in = 16'h00e5;
    status_wr_in = 1'b1;
    read_sel_in = ODP_RSEL_STATUS;
    cyc();
    status_wr_in = 1'b0;
    chk(processor_status_out, 16'h00e5);
    cyc();
    chk(alu_a_operand_out, 16'h00e5);
    read_sel_in = ODP_RSEL_GREG;
  endtask

  task automatic t_bviews(input logic [15:0] h);
    alu_result_in = h;
    dreg_ld_in = 1'b1;
    cyc();
    dreg_ld_in = 1'b0;
    dmux_sel_in = ODP_DSEL_DREG;
    hold_ld_in = 1'b1;
    cyc();
    hold_ld_in = 1'b0;
    dmux_sel_in = ODP_DSEL_READ;
    chk(dmux_out, h);
    // Codes 6 and 7 are unused and must fall back to the direct view
    for (int m = 0; m < 8; m++) begin
      if (m == 5) continue;
      bmode_in = odp_bmode_t'(m);
      cyc();
      chk(alu_b_operand_out, exp_b(bmode_in, h));
    end
  endtask

  task automatic t_consts();
    logic [15:0] kt [10];
    kt = '{16'h0001, 16'h0002, 16'hffff, 16'hfffe, 16'h7f70, 16'h0014, 16'h00ff, 16'hff00,
      16'h00e5, 16'h5aa5};
    bmode_in = ODP_BMODE_CONST;
    for (int j = 0; j < 11; j++) begin
      const_sel_in = 4'(j);
      cyc();
      chk(alu_b_operand_out, (j < 10) ? kt[j] : 16'h0000);
    end
    bmode_in = ODP_BMODE_DIRECT;
  endtask

  task automatic t_result();
    alu_result_in = 16'hc3a1;
    dreg_ld_in = 1'b1;
    addr_ld_in = 1'b1;
    bam_alu_in = 1'b1;
    cyc();
    addr_ld_in = 1'b0;
    alu_result_in = 16'h0ff0;
    chk(bus_addr_out, 16'hc3a1);
    cyc();
    dreg_ld_in = 1'b0;
    chk(dreg_out, 16'h0ff0);
    chk(bus_addr_out, 16'hc3a1);
    addr_ld_in = 1'b1;
    bam_alu_in = 1'b0;
    reg_addr_in = 4'h5;
    cyc();
    addr_ld_in = 1'b0;
    chk(dreg_out, 16'h0ff0);
    chk(bus_addr_out, mem[5]);
  endtask

  task automatic t_shift();
    logic b;
    for (int c = 0; c < 4; c++) begin
      b = (c != 3);
      alu_cout15_in = (c == 0) ? 1'b0 : b;
      alu_cout7_in = (c == 1) ? 1'b0 : b;
      alu_result_in = {(c == 2) ? 1'b0 : b, 15'h2aab};
      carry_out_select_in = odp_csel_t'(c);
      dreg_ld_in = 1'b1;
      cyc();
      dreg_ld_in = 1'b0;
      dmux_sel_in = ODP_DSEL_SHIFT;
      chk({15'h0000, carry_ext_out}, {15'h0000, !b});
      cyc();
      dmux_sel_in = ODP_DSEL_READ;
      chk(dmux_out, {!b, alu_result_in[15:1]});
    end
  endtask

  task automatic t_bus();
    bus_word = 16'h9c3e;
    bus_drv = 1'b1;
    repeat (3) cyc();
    dmux_sel_in = ODP_DSEL_BUS;
    hold_ld_in = 1'b1;
    cyc();
    hold_ld_in = 1'b0;
    dmux_sel_in = ODP_DSEL_READ;
    bus_drv = 1'b0;
    chk(dmux_out, 16'h9c3e);
    cyc();
    chk(alu_b_operand_out, 16'h9c3e);
  endtask

  // Mid-run reset: every data path output must read zero
  task automatic t_reset();
    rst_n_in = 1'b0;
    cyc();
    chk(dreg_out | bus_addr_out | dmux_out | processor_status_out, 16'h0000);
    chk(alu_a_operand_out | alu_b_operand_out, 16'h0000);
    chk({15'h0000, carry_ext_out}, 16'h0000);
    rst_n_in = 1'b1;
    cyc();
    cyc();
    chk(processor_status_out, 16'h0000);
  endtask

  initial begin
    {rst_n_in, reg_wr_in, status_wr_in, hold_ld_in, dreg_ld_in, addr_ld_in} = '0;
    {bam_alu_in, alu_cout15_in, alu_cout7_in, bus_drv} = '0;
    {reg_addr_in, const_sel_in, alu_result_in, bus_word} = '0;
    read_sel_in = ODP_RSEL_NONE;
    dmux_sel_in = ODP_DSEL_READ;
    bmode_in = ODP_BMODE_DIRECT;
    carry_out_select_in = ODP_CSEL_WORD;
    jumper_const_in = 16'h5aa5;
    switch_addr_in = 16'h7f70;
    trap_vector_in = 16'h0014;
    repeat (5) @(posedge clk_in);
    @(negedge clk_in);
    rst_n_in = 1'b1;
    cyc();
    t_regfile();
    t_reg2reg();
    t_bviews(16'h12b4);
    t_bviews(16'h3c5a);
    t_consts();
    t_result();
    t_shift();
    t_bus();
    t_reset();
    finish_test();
  end

  // Whole run needs about 90 cycles; allow ample margin
  initial begin
    #10000;
    n_fail++;
    finish_test();
  end
endmodule
